// file: logic/hcfg_pkg.sv
package hcfg_pkg;
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYCLES = CLK_FREQ_HZ / 1_000_000 * MS_TIME_US;
  localparam int MOD_FREQ_HZ = 120;
  localparam int MOD_HALF_CYCLES = CLK_FREQ_HZ / (2 * MOD_FREQ_HZ);
  localparam int SPI_HALF_CYCLES = 4;
  localparam int IMG_BYTES = 24;
  localparam int NUM_PORTS = 4;
  localparam int NUM_STR = 6;
  localparam int MAX_LANGS = 31;
  // image byte offsets
  localparam int B_SIG = 0;
  localparam int B_OC_TIMER = 7;
  localparam int B_PWR_FS = 8;
  localparam int B_PWR_HS = 9;
  localparam int B_CC_BASE = 12;
  localparam int B_PWR_GOOD = 16;
  localparam int B_DESC_OPT = 17;
  localparam int B_PIN_OPT = 18;
  localparam int B_WPROT = 19;
  localparam int B_LANGS = 20;
  localparam int B_STRINGS = 21;
  localparam int B_ACTIVE = 22;
  localparam int B_REMOVABLE = 23;
  // option bit positions
  localparam int DO_ACCEPT0 = 7;
  localparam int DO_COMPOUND = 6;
  localparam int DO_FS_ONLY = 5;
  localparam int DO_IND_DIS = 4;
  localparam int DO_GANG = 2;
  localparam int PO_AMBER = 7;
  localparam int PO_GREEN = 6;
  localparam int PO_SELF = 5;
  localparam int PO_MOD = 4;
  localparam int PO_PWR_POL = 3;
  localparam int PO_OC_POL = 2;
  localparam int PO_OC_DIS = 1;
  localparam int PO_OC_PP = 0;
  // hub characteristics bits
  localparam int HC_COMPOUND = 2;
  localparam int HC_OC_PP = 3;
  localparam int HC_OC_DIS = 4;
  localparam int HC_IND = 7;
  localparam logic [7:0] SIG_VALUE = 8'hD4;
  localparam logic [7:0] WPROT_CODE = 8'h42;
  localparam logic [7:0] HUB_DESC_TYPE = 8'h29;
  localparam logic [7:0] ZERO_DESC_TYPE = 8'h00;
  localparam logic [7:0] IMG_EE_ADDR = 8'h00;
  localparam logic [7:0] SPI_CMD_READ = 8'h03;
  localparam logic [7:0] SPI_CMD_WREN = 8'h06;
  localparam logic [7:0] SPI_CMD_WRITE = 8'h02;
  // register map, byte addresses
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_EEWR = 6'h08;
  localparam logic [5:0] REG_IMG_BASE = 6'h10;
  localparam logic [5:0] REG_IMG_END = 6'h28;
  localparam int CTRL_RELOAD = 0;
  localparam int ST_REJECT = 3;
  // built-in image, byte 0 in the low bits
  localparam logic [8*IMG_BYTES-1:0] CFG_DEFAULT = {
    8'h0F, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h32,
    8'h64, 8'h50, 8'hAE, 8'h50, 8'h00, 8'h00, 8'h57, 8'h28,
    8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hD4};
endpackage

// file: logic/hcfg_loader.sv
// What this block does
// - overcurrent filter ms from enabled/disabled nibble
// - full-speed attach reports full-speed max power
// - high-speed attach reports high-speed max power unless full-speed-only bit set
// - controller current by speed and power mode
// - report power-good delay byte
// - zero descriptor type accepted or stalled
// - compound bit into characteristics bit 2
// - full-speed-only bit blocks high speed
// - indicator disable blanks LEDs, clears bit 7
// - ganged or per-port power switching reported
// - amber/green LED polarity from bits
// - self-powered only when capable bit set
// - optional 120 Hz indicator modulation
// - power switch output polarity from bit
// - overcurrent input polarity from bit
// - mode bit one disables overcurrent detection
// - mode bit zero selects per-port reporting
// - protect code rejects EEPROM writes
// - zero or over 31 languages disables strings
// - supported string gets nonzero index
// - usable port count from active bits
// - removable bits apply to logical ports
`timescale 1ns/1ps
module hcfg_loader import hcfg_pkg::*; #(
  parameter int MS_COUNT = MS_CYCLES,
  parameter int MOD_HALF = MOD_HALF_CYCLES,
  parameter int SPI_HALF = SPI_HALF_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic SPI_SCK,
  output logic SPI_CS_N,
  output logic SPI_MOSI,
  input wire logic SPI_MISO,
  input wire logic HS_ATTACHED,
  input wire logic SELF_POWERED,
  input wire logic DESC_REQ,
  input wire logic [7:0] DESC_TYPE,
  input wire logic [3:0] PORT_PWR_REQ,
  input wire logic [3:0] OC_IN,
  input wire logic [3:0] AMBER_REQ,
  input wire logic [3:0] GREEN_REQ,
  output logic CFG_VALID,
  output logic HS_ENABLE,
  output logic SELF_MODE,
  output logic [7:0] MAX_POWER,
  output logic [7:0] CONTR_CURRENT,
  output logic [7:0] PWR_GOOD_DELAY,
  output logic [15:0] HUB_CHAR,
  output logic [2:0] NBR_PORTS,
  output logic [4:0] DEV_REMOVABLE,
  output logic STRINGS_EN,
  output logic [4:0] LANG_COUNT,
  output logic [47:0] STR_INDEX,
  output logic DESC_ACCEPT,
  output logic DESC_STALL,
  output logic [3:0] PORT_PWR,
  output logic [3:0] OC_FLAG,
  output logic [3:0] AMBER_LED,
  output logic [3:0] GREEN_LED
);
  typedef enum {S_IDLE, S_FRAME, S_GAP} hcfg_state_e;
  typedef enum {OP_RD, OP_EN, OP_WR} hcfg_op_e;

  localparam logic [15:0] SPI_M1 = 16'(SPI_HALF - 1);
  localparam logic [15:0] MS_M1 = 16'(MS_COUNT - 1);
  localparam logic [15:0] MOD_M1 = 16'(MOD_HALF - 1);

  logic [7:0] img_q [IMG_BYTES];
  hcfg_state_e st_q;
  hcfg_op_e op_q;
  logic [15:0] div_q;
  logic sck_q, cs_n_q, mosi_q;
  logic [2:0] bit_q;
  logic [4:0] bidx_q;
  logic [7:0] sh_q, rx_q;
  logic miso_m_q, miso_s_q;
  logic load_req_q, valid_q, reject_q, wr_pend_q, wait_q;
  logic [7:0] wr_addr_q, wr_data_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////
  // image fields
  wire logic [7:0] desc_opt = img_q[B_DESC_OPT];
  wire logic [7:0] pin_opt = img_q[B_PIN_OPT];
  wire logic [7:0] oc_timer = img_q[B_OC_TIMER];
  wire logic [7:0] langs = img_q[B_LANGS];
  wire logic [7:0] str_map = img_q[B_STRINGS];
  wire logic [3:0] active = img_q[B_ACTIVE][NUM_PORTS-1:0];
  wire logic [3:0] removable = img_q[B_REMOVABLE][NUM_PORTS-1:0];
  wire logic accept0 = desc_opt[DO_ACCEPT0];
  wire logic fs_only = desc_opt[DO_FS_ONLY];
  wire logic ind_dis = desc_opt[DO_IND_DIS];
  wire logic gang = desc_opt[DO_GANG];
  wire logic amber_pol = pin_opt[PO_AMBER];
  wire logic green_pol = pin_opt[PO_GREEN];
  wire logic pwr_pol = pin_opt[PO_PWR_POL];
  wire logic oc_pol = pin_opt[PO_OC_POL];
  wire logic oc_dis = pin_opt[PO_OC_DIS];
  wire logic oc_pp = pin_opt[PO_OC_PP];
  wire logic wr_protected = (img_q[B_WPROT] == WPROT_CODE);

  ////////////////////////////////////////////////////////////////////
  // spi master, mode 0; MISO sampled late in the high phase so that
  // the two-stage synchroniser delay stays inside it (SPI_HALF >= 3)
  wire logic div_done = (div_q == 16'h0000);
  wire logic rise = (st_q == S_FRAME) && div_done && !sck_q;
  wire logic fall = (st_q == S_FRAME) && div_done && sck_q;
  wire logic byte_end = fall && (bit_q == 3'd7);
  wire logic [7:0] rx_byte = {rx_q[6:0], miso_s_q};
  wire logic [4:0] bidx_inc = bidx_q + 5'd1;
  wire logic [4:0] last_idx = (op_q == OP_RD) ? 5'(IMG_BYTES + 1) :
                              (op_q == OP_EN) ? 5'd0 : 5'd2;
  wire logic frame_end = byte_end && (bidx_q == last_idx);
  wire logic start_any = (st_q == S_IDLE) && (load_req_q || wr_pend_q);
  wire logic [7:0] tx_first = load_req_q ? SPI_CMD_READ : SPI_CMD_WREN;
  wire logic [7:0] tx_next = (op_q == OP_RD) ? IMG_EE_ADDR :
                             (bidx_inc == 5'd1) ? wr_addr_q : wr_data_q;
  wire logic load_done = (st_q == S_GAP) && div_done && (op_q == OP_RD);
  wire logic img_wr = byte_end && (op_q == OP_RD) && (bidx_q >= 5'd2);
  wire logic [4:0] img_idx = bidx_q - 5'd2;
  wire logic sig_ok = (img_q[B_SIG] == SIG_VALUE);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end else begin
      miso_m_q <= SPI_MISO;
      miso_s_q <= miso_m_q;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= S_IDLE;
      op_q <= OP_RD;
      div_q <= 16'h0000;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      bit_q <= 3'd0;
      bidx_q <= 5'd0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
    end else begin
      div_q <= div_done ? SPI_M1 : div_q - 16'd1;
      case (st_q)
        S_IDLE: if (start_any) begin
          op_q <= load_req_q ? OP_RD : OP_EN;
          st_q <= S_FRAME;
          cs_n_q <= 1'b0;
          bidx_q <= 5'd0;
          sh_q <= tx_first;
          mosi_q <= tx_first[7];
          div_q <= SPI_M1;
        end
        S_FRAME: begin
          if (rise) sck_q <= 1'b1;
          if (fall) begin
            sck_q <= 1'b0;
            rx_q <= rx_byte;
            bit_q <= bit_q + 3'd1;
            if (frame_end) begin
              cs_n_q <= 1'b1;
              st_q <= S_GAP;
            end else if (byte_end) begin
              bidx_q <= bidx_inc;
              sh_q <= tx_next;
              mosi_q <= tx_next[7];
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              mosi_q <= sh_q[6];
            end
          end
        end
        S_GAP: if (div_done) begin
          if (op_q == OP_EN) begin
            op_q <= OP_WR;
            st_q <= S_FRAME;
            cs_n_q <= 1'b0;
            bidx_q <= 5'd0;
            sh_q <= SPI_CMD_WRITE;
            mosi_q <= SPI_CMD_WRITE[7];
          end else begin
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // loaded bytes go straight into the live image; outputs follow the
  // image while a reload runs, which software sees as busy
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < IMG_BYTES; i++) img_q[i] <= CFG_DEFAULT[8*i +: 8];
    end else if (load_done && !sig_ok) begin
      for (int i = 0; i < IMG_BYTES; i++) img_q[i] <= CFG_DEFAULT[8*i +: 8];
    end else if (img_wr) begin
      img_q[img_idx] <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, effect at the edge with waitrequest low
  wire logic av_wr = AVS_WRITE && !wait_q;
  wire logic wr_ctrl = av_wr && (AVS_ADDRESS == REG_CTRL);
  wire logic wr_stat = av_wr && (AVS_ADDRESS == REG_STATUS);
  wire logic wr_ee = av_wr && (AVS_ADDRESS == REG_EEWR);
  wire logic busy = (st_q != S_IDLE) || load_req_q || wr_pend_q;
  wire logic ee_refuse = wr_protected || wr_pend_q;
  wire logic [5:0] img_off = AVS_ADDRESS - REG_IMG_BASE;
  wire logic [4:0] ib = {img_off[4:2], 2'b00};
  logic [31:0] rd_mux;

  always_comb begin
    if (AVS_ADDRESS == REG_CTRL) begin
      rd_mux = {31'h0, load_req_q};
    end else if (AVS_ADDRESS == REG_STATUS) begin
      rd_mux = {28'h0, reject_q, wr_protected, valid_q, busy};
    end else if (AVS_ADDRESS == REG_EEWR) begin
      rd_mux = {16'h0, wr_addr_q, wr_data_q};
    end else if (AVS_ADDRESS >= REG_IMG_BASE && AVS_ADDRESS < REG_IMG_END) begin
      rd_mux = {img_q[ib + 5'd3], img_q[ib + 5'd2], img_q[ib + 5'd1], img_q[ib]};
    end else begin
      rd_mux = 32'h0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
      if (AVS_READ && wait_q) rdata_q <= rd_mux;
    end
  end

  // hardware set wins over software clear on the sticky reject flag
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      load_req_q <= 1'b1;
      valid_q <= 1'b0;
      reject_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      if (wr_ctrl && AVS_WRITEDATA[CTRL_RELOAD]) load_req_q <= 1'b1;
      else if (start_any && load_req_q) load_req_q <= 1'b0;
      if (load_done) valid_q <= sig_ok;
      if (wr_ee && ee_refuse) reject_q <= 1'b1;
      else if (wr_stat && AVS_WRITEDATA[ST_REJECT]) reject_q <= 1'b0;
      if (wr_ee && !ee_refuse) begin
        wr_pend_q <= 1'b1;
        wr_addr_q <= AVS_WRITEDATA[15:8];
        wr_data_q <= AVS_WRITEDATA[7:0];
      end else if (start_any && !load_req_q) begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // descriptor values
  wire logic hs_eff = HS_ATTACHED && !fs_only;
  wire logic self_eff = SELF_POWERED && pin_opt[PO_SELF];
  wire logic [4:0] cc_idx = 5'(B_CC_BASE) + {3'b000, self_eff, hs_eff};
  wire logic [7:0] cc_sel = img_q[cc_idx];
  wire logic [2:0] n_ports = 3'($countones(active));
  wire logic str_en = (langs != 8'h00) && (langs <= 8'(MAX_LANGS));
  logic [15:0] hc_d;
  logic [4:0] rem_d;
  logic [47:0] str_d;

  always_comb begin
    hc_d = 16'h0000;
    hc_d[1:0] = gang ? 2'b00 : 2'b01;
    hc_d[HC_COMPOUND] = desc_opt[DO_COMPOUND];
    hc_d[HC_OC_PP] = oc_pp;
    hc_d[HC_OC_DIS] = oc_dis;
    hc_d[HC_IND] = !ind_dis;
    rem_d = 5'h00;
    for (int j = 1; j <= NUM_PORTS; j++) begin
      if (j <= int'(n_ports)) rem_d[j] = removable[j-1];
    end
    str_d = 48'h0;
    for (int k = 0; k < NUM_STR; k++) begin
      if (str_en && str_map[k]) str_d[8*k +: 8] = 8'(k + 1);
    end
  end

  wire logic desc_ok = (DESC_TYPE == HUB_DESC_TYPE) ||
                       ((DESC_TYPE == ZERO_DESC_TYPE) && accept0);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HS_ENABLE <= 1'b0;
      SELF_MODE <= 1'b0;
      MAX_POWER <= 8'h00;
      CONTR_CURRENT <= 8'h00;
      PWR_GOOD_DELAY <= 8'h00;
      HUB_CHAR <= 16'h0000;
      NBR_PORTS <= 3'd0;
      DEV_REMOVABLE <= 5'h00;
      STRINGS_EN <= 1'b0;
      LANG_COUNT <= 5'h00;
      STR_INDEX <= 48'h0;
      DESC_ACCEPT <= 1'b0;
      DESC_STALL <= 1'b0;
    end else begin
      HS_ENABLE <= !fs_only;
      SELF_MODE <= self_eff;
      MAX_POWER <= hs_eff ? img_q[B_PWR_HS] : img_q[B_PWR_FS];
      CONTR_CURRENT <= cc_sel;
      PWR_GOOD_DELAY <= img_q[B_PWR_GOOD];
      HUB_CHAR <= hc_d;
      NBR_PORTS <= n_ports;
      DEV_REMOVABLE <= rem_d;
      STRINGS_EN <= str_en;
      LANG_COUNT <= str_en ? langs[4:0] : 5'h00;
      STR_INDEX <= str_d;
      DESC_ACCEPT <= DESC_REQ && desc_ok;
      DESC_STALL <= DESC_REQ && !desc_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // port power, overcurrent filter, indicators
  wire logic [3:0] pwr_on = (gang ? {4{|(PORT_PWR_REQ & active)}} : PORT_PWR_REQ)
                            & active;
  logic [3:0] oc_m_q, oc_s_q;
  logic [15:0] ms_q, mod_q;
  logic wave_q;
  wire logic ms_tick = (ms_q == MS_M1);
  wire logic [3:0] oc_act = oc_pol ? oc_s_q : ~oc_s_q;
  logic [3:0] oc_hit;

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_oc
    logic [3:0] cnt_q;
    logic hit_q;
    wire logic [3:0] thr = pwr_on[i] ? oc_timer[7:4] : oc_timer[3:0];
    assign oc_hit[i] = hit_q;
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        cnt_q <= 4'h0;
        hit_q <= 1'b0;
      end else if (!oc_act[i]) begin
        cnt_q <= 4'h0;
        hit_q <= 1'b0;
      end else if (cnt_q >= thr) begin
        hit_q <= 1'b1;
      end else if (ms_tick) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  wire logic [3:0] oc_port = oc_hit & active;
  wire logic [3:0] oc_d = oc_dis ? 4'h0 :
                          oc_pp ? oc_port : {4{|oc_port}};
  wire logic [3:0] led_gate = active & {4{!ind_dis}} &
                              ((pin_opt[PO_MOD] && !wave_q) ? 4'h0 : 4'hF);
  wire logic [3:0] amber_on = AMBER_REQ & led_gate;
  wire logic [3:0] green_on = GREEN_REQ & led_gate;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      oc_m_q <= 4'h0;
      oc_s_q <= 4'h0;
      ms_q <= 16'h0000;
      mod_q <= 16'h0000;
      wave_q <= 1'b0;
      PORT_PWR <= 4'h0;
      OC_FLAG <= 4'h0;
      AMBER_LED <= 4'h0;
      GREEN_LED <= 4'h0;
    end else begin
      oc_m_q <= OC_IN;
      oc_s_q <= oc_m_q;
      ms_q <= ms_tick ? 16'h0000 : ms_q + 16'd1;
      mod_q <= (mod_q == MOD_M1) ? 16'h0000 : mod_q + 16'd1;
      if (mod_q == MOD_M1) wave_q <= !wave_q;
      PORT_PWR <= pwr_pol ? pwr_on : ~pwr_on;
      OC_FLAG <= oc_d;
      AMBER_LED <= amber_pol ? amber_on : ~amber_on;
      GREEN_LED <= green_pol ? green_on : ~green_on;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;
  assign SPI_SCK = sck_q;
  assign SPI_CS_N = cs_n_q;
  assign SPI_MOSI = mosi_q;
  assign CFG_VALID = valid_q;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_zero_req;
    DESC_REQ && (DESC_TYPE == ZERO_DESC_TYPE);
  endsequence
  sequence s_prot_write;
    wr_ee && wr_protected;
  endsequence
  sequence s_ind_off_held;
    ind_dis ##1 (ind_dis && $stable(pin_opt));
  endsequence

  property p_oc_filter;
    $rose(g_oc[0].hit_q) |-> $past(oc_act[0]) && ($past(g_oc[0].cnt_q) >= $past(g_oc[0].thr));
  endproperty
  a_oc_filter: assert property (p_oc_filter) else $error("oc flag before filter time");
  // reset lifts on a clock edge; the sampled RESET_N keeps that edge's attempt out
  property p_max_fs;
    RESET_N && !hs_eff |=> MAX_POWER == $past(img_q[B_PWR_FS]);
  endproperty
  a_max_fs: assert property (p_max_fs) else $error("wrong full-speed power");
  property p_max_hs;
    RESET_N && hs_eff |=> MAX_POWER == $past(img_q[B_PWR_HS]);
  endproperty
  a_max_hs: assert property (p_max_hs) else $error("wrong high-speed power");
  property p_zero_desc;
    s_zero_req |=> (DESC_STALL != $past(accept0)) && (DESC_ACCEPT == $past(accept0));
  endproperty
  a_zero_desc: assert property (p_zero_desc) else $error("zero type mishandled");
  property p_ind_off;
    s_ind_off_held |=> AMBER_LED == {4{!$past(amber_pol)}} && GREEN_LED == {4{!$past(green_pol)}};
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator lit while disabled");
  property p_pwr_pol;
    RESET_N |=> PORT_PWR == ($past(pwr_pol) ? $past(pwr_on) : ~$past(pwr_on));
  endproperty
  a_pwr_pol: assert property (p_pwr_pol) else $error("power pin polarity wrong");
  property p_oc_dis;
    oc_dis |=> OC_FLAG == 4'h0;
  endproperty
  a_oc_dis: assert property (p_oc_dis) else $error("oc reported while disabled");
  property p_wprot;
    s_prot_write |=> reject_q && (wr_pend_q == $past(wr_pend_q));
  endproperty
  a_wprot: assert property (p_wprot) else $error("protected write not refused");
  property p_strings_off;
    !str_en |=> !STRINGS_EN && STR_INDEX == 48'h0;
  endproperty
  a_strings_off: assert property (p_strings_off) else $error("strings not disabled");
  property p_ports;
    RESET_N |=> NBR_PORTS == 3'($countones($past(active)));
  endproperty
  a_ports: assert property (p_ports) else $error("port count wrong");
  property p_fallback;
    load_done && !sig_ok |=> !valid_q && img_q[B_OC_TIMER] == CFG_DEFAULT[8*B_OC_TIMER +: 8];
  endproperty
  a_fallback: assert property (p_fallback) else $error("no default fallback");
endmodule // hcfg_loader

// file: tb/hcfg_eeprom.sv
`timescale 1ns/1ps
module hcfg_eeprom (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] mem [256];
  logic [7:0] sr, cmd, ptr, o;
  logic wel, rd;
  int bc;
  initial begin
    miso = 1'b0;
    wel = 1'b0;
    rd = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[0] = 8'hD4;
    {mem[7], mem[8], mem[9]} = {8'h21, 8'h11, 8'h22};
    {mem[12], mem[13], mem[14], mem[15], mem[16]} = {8'h31, 8'h32, 8'h33, 8'h34, 8'h44};
    {mem[17], mem[18], mem[20]} = {8'hC4, 8'hEC, 8'h03};
    {mem[21], mem[22], mem[23]} = {8'h25, 8'h0B, 8'h05};
  end
  always @(negedge cs_n) begin
    bc = 0;
    rd = 1'b0;
  end
  // a released line must not keep showing the last bit
  always @(posedge cs_n) miso = ~miso;
  always @(posedge sck) if (!cs_n) begin
    sr = {sr[6:0], mosi};
    bc++;
    if (bc == 8) cmd = sr;
    if (bc == 8 && sr == 8'h06) wel = 1'b1;
    if (bc == 16) begin
      ptr = sr;
      rd = (cmd == 8'h03);
    end
    if (bc == 24 && cmd == 8'h02 && wel) begin
      mem[ptr] = sr;
      wel = 1'b0;
    end
  end
  always @(negedge sck) if (!cs_n && rd) begin
    if (bc % 8 == 0) begin
      o = mem[ptr];
      ptr++;
    end
    miso = o[7];
    o = o << 1;
  end
endmodule // hcfg_eeprom

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import hcfg_pkg::*;
  localparam logic [7:0] SMAP = 8'h25;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, hs = 1'b0, sp = 1'b0, dreq = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdat = 32'h0, rdata, q;
  logic [7:0] dtype = 8'h00, max_pw, cc, pgd;
  logic [3:0] preq = 4'h0, oc_in = 4'hF, areq = 4'h0, greq = 4'h0, ppw, ocf, amb, grn;
  logic waitreq, sck, cs_n, mosi, miso, valid, hs_en, self_m, str_en, acc, stall;
  logic [15:0] hchar;
  logic [2:0] nports;
  logic [4:0] rem, lang;
  logic [47:0] stri;
  int n_fail = 0, tests_run = 0, cyc = 0, on, off;
  always #50 clk = ~clk;
  hcfg_loader #(.MS_COUNT(10), .MOD_HALF(8), .SPI_HALF(4)) dut (
    .CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso),
    .HS_ATTACHED(hs), .SELF_POWERED(sp), .DESC_REQ(dreq), .DESC_TYPE(dtype),
    .PORT_PWR_REQ(preq), .OC_IN(oc_in), .AMBER_REQ(areq), .GREEN_REQ(greq),
    .CFG_VALID(valid), .HS_ENABLE(hs_en), .SELF_MODE(self_m), .MAX_POWER(max_pw),
    .CONTR_CURRENT(cc), .PWR_GOOD_DELAY(pgd), .HUB_CHAR(hchar), .NBR_PORTS(nports),
    .DEV_REMOVABLE(rem), .STRINGS_EN(str_en), .LANG_COUNT(lang), .STR_INDEX(stri),
    .DESC_ACCEPT(acc), .DESC_STALL(stall), .PORT_PWR(ppw), .OC_FLAG(ocf),
    .AMBER_LED(amb), .GREEN_LED(grn));
  hcfg_eeprom u_ee (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // pending reload shows in CTRL and in busy in the same cycle; both are polled
  task automatic idle();
    logic s;
    do begin
      av(1'b0, REG_CTRL, 32'h0);
      s = q[0];
      av(1'b0, REG_STATUS, 32'h0);
    end while (s !== 1'b0 || q[0] !== 1'b0);
    repeat (3) @(posedge clk);
  endtask
  task automatic ee_wr(input logic [7:0] a, input logic [7:0] d);
    av(1'b1, REG_EEWR, {16'h0, a, d});
    idle();
  endtask
  task automatic reload();
    av(1'b1, REG_CTRL, 32'h1);
    idle();
  endtask
  task automatic desc(input logic [7:0] t, input logic a);
    @(posedge clk);
    dreq <= 1'b1;
    dtype <= t;
    @(posedge clk);
    dreq <= 1'b0;
    @(posedge clk);
    chk({acc, stall}, {a, !a});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(max_pw, 8'h28);
    idle();
    $display("test defaults done");
    oc_in <= 4'h0;
    chk(valid, 1'b1);
    av(1'b0, REG_IMG_BASE + 6'h0C, 32'h0);
    chk(q, 32'h34333231);
    av(1'b0, 6'h3C, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      hs <= i[0];
      sp <= i[1];
      repeat (3) @(posedge clk);
      chk(cc, 8'(8'h31 + i));
      chk(max_pw, i[0] ? 8'h22 : 8'h11);
      chk(self_m, i[1]);
    end
    chk(hchar, 16'h0084);
    chk({pgd, nports, rem}, {8'h44, 3'd3, 5'h0A});
    chk({str_en, lang}, {1'b1, 5'd3});
    for (int k = 0; k < 6; k++) begin
      chk(stri[8*k +: 8] != 8'h00, SMAP[k]);
    end
    desc(8'h00, 1'b1);
    desc(HUB_DESC_TYPE, 1'b1);
    areq <= 4'h5;
    greq <= 4'hA;
    preq <= 4'h1;
    repeat (3) @(posedge clk);
    // physical port 2 is not usable, so its indicator stays dark
    chk({amb, grn, ppw}, {4'h1, 4'hA, 4'hB});
    oc_in <= 4'h1;
    repeat (5) @(posedge clk);
    chk(ocf, 4'h0);
    repeat (40) @(posedge clk);
    chk(ocf[1:0], 2'b11);
    oc_in <= 4'h0;
    $display("test image_a done");
    ee_wr(8'd17, 8'h20);
    ee_wr(8'd18, 8'h13);
    ee_wr(8'd20, 8'h20);
    reload();
    chk({hs_en, self_m, str_en}, 3'b000);
    chk(hchar, 16'h0099);
    desc(8'h00, 1'b0);
    areq <= 4'hF;
    repeat (40) @(posedge clk);
    chk({ppw, ocf}, {4'hE, 4'h0});
    on = 0;
    off = 0;
    for (int c = 0; c < 32; c++) begin
      @(posedge clk);
      on += int'(amb === 4'h4);
      off += int'(amb === 4'hF);
    end
    chk(on > 8 && off > 8, 1'b1);
    $display("test image_b done");
    ee_wr(8'd17, 8'h10);
    ee_wr(8'd19, WPROT_CODE);
    reload();
    greq <= 4'hF;
    repeat (3) @(posedge clk);
    chk({hchar, amb, grn}, {16'h0019, 8'hFF});
    av(1'b0, REG_STATUS, 32'h0);
    chk(q[3:2], 2'b01);
    ee_wr(8'd5, 8'h77);
    av(1'b0, REG_STATUS, 32'h0);
    chk({q[3], u_ee.mem[5]}, {1'b1, 8'h00});
    av(1'b1, REG_STATUS, 32'h8);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q[3], 1'b0);
    $display("test protect done");
    u_ee.mem[0] = 8'h00;
    reload();
    hs <= 1'b1;
    repeat (3) @(posedge clk);
    chk({valid, hchar, pgd, max_pw}, {1'b0, 16'h0081, 8'h32, 8'h57});
    $display("test bad_image done");
    end_of_test();
  end
endmodule // tb
